// ### spp_checker.sv
// Port assertions for the serial peripheral port
`timescale 1ns/1ps
module spp_checker
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins and requests
    input wire spp_pkg::spp_pins_s pins_o,
    input wire logic dma_tx_sreq_o,
    input wire logic dma_tx_breq_o,
    input wire logic dma_rx_sreq_o,
    input wire logic dma_rx_breq_o
);
    import spp_pkg::*;
    logic prev_r;
    logic prev_nxt;
    logic [7:0] hold_r;
    logic [7:0] hold_nxt;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Cycles the serial clock held its level; saturates so idle gaps read long
    always_comb
    begin
        prev_nxt = pins_o.sclk;
        hold_nxt = (hold_r == 8'hff) ? hold_r : hold_r + 8'h01;
        if (rst_i)
            hold_nxt = 8'hff;
        else if (pins_o.sclk != prev_r)
            hold_nxt = 8'h00;
    end
    always_ff @(posedge clk_i)
    begin
        prev_r <= prev_nxt;
        hold_r <= hold_nxt;
    end
    // Bus answer timing
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
    // Serial clock and select shape
    half_min_a: assert property (!pins_o.sclk_oe_n && pins_o.sclk != prev_r |-> hold_r >= MIN_HALF[7:0] - 8'h01)
        else $error("serial clock half too short");
    sclk_idle_a: assert property (pins_o.cs_n && $past(pins_o.cs_n) && !pins_o.sclk_oe_n &&
        !$past(pins_o.sclk_oe_n) |-> $stable(pins_o.sclk)) else $error("serial clock moved while deselected");
    cs_gap_a: assert property ($rose(pins_o.cs_n) && !pins_o.cs_oe_n |=> pins_o.cs_n [*8])
        else $error("select pulse too short");
    // Pin roles and requests
    oe_pair_a: assert property (!pins_o.cs_oe_n |-> !pins_o.sclk_oe_n && !pins_o.dout_oe_n)
        else $error("master pins not driven together");
    dma_tx_a: assert property (dma_tx_breq_o |-> dma_tx_sreq_o) else $error("tx burst without single");
    dma_rx_a: assert property (dma_rx_breq_o |-> dma_rx_sreq_o) else $error("rx burst without single");
    cover property ($fell(pins_o.cs_n));
    cover property (dma_rx_breq_o);
    cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule

bind spp_top spp_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_o(pins_o), .dma_tx_sreq_o(dma_tx_sreq_o),
    .dma_tx_breq_o(dma_tx_breq_o), .dma_rx_sreq_o(dma_rx_sreq_o), .dma_rx_breq_o(dma_rx_breq_o));

// ### spp_partner.sv
// Behavioural external serial slave facing the port
`timescale 1ns/1ps
module spp_partner
#(
    parameter logic [31:0] PAT = 32'h5ac396e1
)
(
    // Pins from the port
    input wire spp_pkg::spp_pins_s pins_i,
    // Link mode
    input wire logic pha_i,
    input wire logic pol_i,
    // Data back
    output logic so_o
);
    import spp_pkg::*;
    logic [31:0] rx_word = 32'h0;
    logic [4:0] idx = 5'h00;
    int frames = 0;
    longint t_last = 0;
    longint half_ns = 0;
    wire lead = pins_i.sclk ^ pol_i ^ pha_i;
    initial so_o = 1'b0;
    // First bit as select falls; phase 1 drives it again on its first edge
    always @(negedge pins_i.cs_n)
    begin
        idx = pha_i ? 5'h00 : 5'h01;
        so_o <= PAT[31];
    end
    // Released line shows the inverse of its last value
    always @(posedge pins_i.cs_n)
    begin
        so_o <= ~so_o;
        frames++;
    end
    // Capture on the sampling edge; guard on enable, since select can rise with the last edge
    always @(posedge lead)
        if (!pins_i.sclk_oe_n)
            rx_word <= {rx_word[30:0], pins_i.dout};
    always @(negedge lead)
        if (!pins_i.sclk_oe_n)
        begin
            so_o <= PAT[~idx];
            idx = idx + 5'h01;
        end
    // Time between serial clock edges
    always @(pins_i.sclk)
        if (!pins_i.sclk_oe_n)
        begin
            half_ns = $time - t_last;
            t_last = $time;
        end
endmodule

// ### spp_pkg.sv
// Constants, types and register map of the serial peripheral port
// Notes on behaviour
// - master up to 8 MHz, slave 1 MHz
// - transmit words queue in 16x32 FIFO
// - received words buffer in 16x32 FIFO
// - frame length programmable 4 to 32 bits
// - pin roles swap between master and slave
// - one system word fills one FIFO entry
// - FIFOs serve bursts of one to eight
// - DMA request handshake for both FIFOs
// - phase0 polarity0: sample rising, idle low
// - phase0 polarity1: sample falling, idle high
// - phase1 polarity0: drive rising, sample falling
// - phase1 polarity1: drive falling, sample rising
// - phase0 pulses chip select between words
// - rate is clk/(even prescale)/(1+factor)
// - serial clock always 50 percent duty
// - disabling keeps both FIFO contents intact
// - transmit byte and bit order select
// - receive uses same order encoding
// - mixed orders only for 16/24/32 bits
package spp_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL_A = 8'h00;
    localparam logic [7:0] REG_CTRL_B = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_PRESCALE = 8'h10;
    localparam logic [7:0] REG_DMA = 8'h14;
    // Writable bits and reset values
    localparam logic [31:0] CTRL_A_MASK = 32'h0000ffdf;
    localparam logic [31:0] CTRL_A_RESET = 32'h00000007;
    localparam logic [31:0] CTRL_B_MASK = 32'h000000f6;
    localparam logic [31:0] CTRL_B_RESET = 32'h00000000;
    localparam logic [31:0] PRESCALE_MASK = 32'h000000fe;
    localparam logic [31:0] PRESCALE_RESET = 32'h00000002;
    localparam logic [31:0] DMA_MASK = 32'h00000003;
    // Field positions
    localparam int A_SIZE_LSB = 0;
    localparam int A_PHASE_BIT = 6;
    localparam int A_POL_BIT = 7;
    localparam int A_RATE_LSB = 8;
    localparam int B_ENABLE_BIT = 1;
    localparam int B_SLAVE_BIT = 2;
    localparam int B_TXORD_LSB = 4;
    localparam int B_RXORD_LSB = 6;
    localparam int S_OVR_BIT = 5;
    localparam int S_UND_BIT = 6;
    localparam int DMA_TX_BIT = 0;
    localparam int DMA_RX_BIT = 1;
    // FIFO geometry and burst size
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] FIFO_FULL = 5'h10;
    localparam logic [4:0] BURST_WORDS = 5'h08;
    localparam logic [4:0] MIN_SIZE_M1 = 5'h03;
    // Order codes: bit0 low byte first, bit1 low bit first
    localparam logic [1:0] ORD_MSB_MSB = 2'h0;
    localparam logic [1:0] ORD_LSB_MSB = 2'h1;
    localparam logic [1:0] ORD_MSB_LSB = 2'h2;
    // Timing
    localparam int CLK_HZ = 250000000;
    localparam int MASTER_MAX_HZ = 8000000;
    localparam int SLAVE_MAX_HZ = 1000000;
    localparam int MIN_HALF_CYC = (CLK_HZ + 2 * MASTER_MAX_HZ - 1) / (2 * MASTER_MAX_HZ);
    localparam logic [15:0] MIN_HALF = 16'(MIN_HALF_CYC);

    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_XFER, ST_GAP} spp_state_e;

    typedef struct packed {
        logic enable;
        logic slave;
        logic phase;
        logic polarity;
        logic [4:0] size_m1;
        logic [7:0] rate;
        logic [1:0] tx_order;
        logic [1:0] rx_order;
    } spp_cfg_s;

    typedef struct packed {
        logic sclk;
        logic sclk_oe_n;
        logic cs_n;
        logic cs_oe_n;
        logic dout;
        logic dout_oe_n;
    } spp_pins_s;
endpackage

// ### spp_top.sv
// Serial peripheral port: FIFOs, shift engine, clock divider and Wishbone slave
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
module spp_fifo
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Write side
    input wire logic push_i,
    input wire logic [31:0] wdata_i,
    // Read side
    input wire logic pop_i,
    output logic [31:0] rdata_o,
    output logic [4:0] count_o
);
    import spp_pkg::*;

    logic [31:0] mem_r [FIFO_DEPTH];
    logic [31:0] mem_nxt [FIFO_DEPTH];
    logic [3:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic do_push, do_pop;

    // Pointer and storage update; a full FIFO drops the write
    always_comb
    begin
        mem_nxt = mem_r;
        do_push = push_i && (cnt_r != FIFO_FULL);
        do_pop = pop_i && (cnt_r != 5'h00);
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        if (do_push)
        begin
            mem_nxt[wr_r] = wdata_i;
            wr_nxt = wr_r + 4'h1;
        end
        if (do_pop)
        begin
            rd_nxt = rd_r + 4'h1;
        end
        cnt_nxt = cnt_r + {4'h0, do_push} - {4'h0, do_pop};
    end

    // Storage needs no reset; only pointers and count carry control state
    always_ff @(posedge clk_i)
    begin
        mem_r <= mem_nxt;
        if (rst_i)
        begin
            wr_r <= 4'h0;
            rd_r <= 4'h0;
            cnt_r <= 5'h00;
        end
        else
        begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign rdata_o = mem_r[rd_r];
    assign count_o = cnt_r;
endmodule

module spp_top
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial pins
    input wire logic spi_in_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    output spp_pkg::spp_pins_s pins_o,
    // DMA requests
    output logic dma_tx_sreq_o,
    output logic dma_tx_breq_o,
    output logic dma_rx_sreq_o,
    output logic dma_rx_breq_o
);
    import spp_pkg::*;

    // Position of transmitted bit k inside the element
    function automatic logic [4:0] bit_index(input logic [4:0] k, input logic [4:0] lm1, input logic [1:0] ord);
        logic [1:0] nb;
        nb = lm1[4:3] - k[4:3];
        case (ord)
            ORD_MSB_MSB: bit_index = lm1 - k;
            ORD_LSB_MSB: bit_index = {k[4:3], ~k[2:0]};
            ORD_MSB_LSB: bit_index = {nb, k[2:0]};
            default: bit_index = k;
        endcase
    endfunction

    // Byte-lane merge of a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel,
                                          input logic [31:0] mask);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                m[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        merge = m & mask;
    endfunction

    logic [31:0] ctrl_a_r, ctrl_a_nxt, ctrl_b_r, ctrl_b_nxt, pre_r, pre_nxt, dma_r, dma_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic ack_r, ack_nxt, ovr_r, ovr_nxt, und_r, und_nxt;
    logic dts_r, dts_nxt, dtb_r, dtb_nxt, drs_r, drs_nxt, drb_r, drb_nxt;
    spp_cfg_s cfg;
    spp_state_e state_r, state_nxt;
    logic [15:0] div_r, div_nxt;
    logic [5:0] edge_r, edge_nxt;
    logic [31:0] txw_r, txw_nxt, rxw_r, rxw_nxt;
    logic sprev_r;
    spp_pins_s pins_r, pins_nxt;
    logic req, tx_push, rx_pop, tx_pop, rx_push, ovr_set, und_set;
    logic [31:0] tx_rdata, rx_rdata;
    logic [4:0] tx_cnt, rx_cnt, lm1, k, didx;
    logic master, tick, evt, lead, sample;
    logic [6:0] ph;
    logic [8:0] rf;
    logic [15:0] half_prod, half_len;

    // Configuration fields; short sizes read as four bits
    assign cfg.enable = ctrl_b_r[B_ENABLE_BIT];
    assign cfg.slave = ctrl_b_r[B_SLAVE_BIT];
    assign cfg.phase = ctrl_a_r[A_PHASE_BIT];
    assign cfg.polarity = ctrl_a_r[A_POL_BIT];
    assign cfg.size_m1 = ctrl_a_r[A_SIZE_LSB +: 5];
    assign cfg.rate = ctrl_a_r[A_RATE_LSB +: 8];
    assign cfg.tx_order = ctrl_b_r[B_TXORD_LSB +: 2];
    assign cfg.rx_order = ctrl_b_r[B_RXORD_LSB +: 2];
    assign lm1 = (cfg.size_m1 < MIN_SIZE_M1) ? MIN_SIZE_M1 : cfg.size_m1;
    assign master = ~cfg.slave;

    // Half period = (prescale/2)*(1+factor); even split keeps 50 percent duty
    assign ph = (pre_r[7:1] == 7'h00) ? 7'h01 : pre_r[7:1];
    assign rf = {1'b0, cfg.rate} + 9'h001;
    assign half_prod = {9'h000, ph} * {7'h00, rf};
    // Clamp keeps master bit rate at or below its limit
    assign half_len = (half_prod < MIN_HALF) ? MIN_HALF : half_prod;
    assign tick = master && (div_r == half_len - 16'h0001);
    assign evt = master ? tick : (sclk_i != sprev_r);

    // Both FIFOs ignore the enable, so data survives a disable
    spp_fifo u_tx_fifo
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .push_i(tx_push),
        .wdata_i(wb_dat_i),
        .pop_i(tx_pop),
        .rdata_o(tx_rdata),
        .count_o(tx_cnt)
    );
    spp_fifo u_rx_fifo
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .push_i(rx_push),
        .wdata_i(rxw_nxt),
        .pop_i(rx_pop),
        .rdata_o(rx_rdata),
        .count_o(rx_cnt)
    );

    // Shift engine next state
    always_comb
    begin
        state_nxt = state_r;
        edge_nxt = edge_r;
        txw_nxt = txw_r;
        rxw_nxt = rxw_r;
        pins_nxt = pins_r;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        ovr_set = 1'b0;
        und_set = 1'b0;
        k = edge_r[5:1];
        lead = ~edge_r[0];
        sample = cfg.phase ? ~lead : lead;
        didx = cfg.phase ? k : k + 5'h01;
        div_nxt = (state_r == ST_IDLE || tick) ? 16'h0000 : div_r + 16'h0001;
        pins_nxt.sclk_oe_n = ~(cfg.enable & master);
        pins_nxt.cs_oe_n = ~(cfg.enable & master);
        pins_nxt.dout_oe_n = ~(cfg.enable & (master | ~cs_n_i));
        if (!cfg.enable)
        begin
            state_nxt = ST_IDLE;
            pins_nxt.sclk = cfg.polarity;
            pins_nxt.cs_n = 1'b1;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    pins_nxt.sclk = cfg.polarity;
                    if (master ? (tx_cnt != 5'h00) : ~cs_n_i)
                    begin
                        tx_pop = (tx_cnt != 5'h00);
                        und_set = (tx_cnt == 5'h00);
                        txw_nxt = (tx_cnt != 5'h00) ? tx_rdata : 32'h00000000;
                        rxw_nxt = 32'h00000000;
                        edge_nxt = 6'h00;
                        pins_nxt.dout = txw_nxt[bit_index(5'h00, lm1, cfg.tx_order)];
                        pins_nxt.cs_n = 1'b0;
                        state_nxt = master ? ST_LEAD : ST_XFER;
                    end
                    else
                    begin
                        pins_nxt.cs_n = 1'b1;
                    end
                end
                ST_LEAD:
                begin
                    // Half period here, then another in ST_XFER before the first edge
                    if (tick)
                    begin
                        state_nxt = ST_XFER;
                    end
                end
                ST_XFER:
                begin
                    if (!master && cs_n_i)
                    begin
                        // Slave deselected mid frame: partial word dropped
                        state_nxt = ST_IDLE;
                    end
                    else if (evt)
                    begin
                        if (master)
                        begin
                            pins_nxt.sclk = ~pins_r.sclk;
                        end
                        if (sample)
                        begin
                            rxw_nxt[bit_index(k, lm1, cfg.rx_order)] = spi_in_i;
                        end
                        else if (cfg.phase || (k != lm1))
                        begin
                            pins_nxt.dout = txw_r[bit_index(didx, lm1, cfg.tx_order)];
                        end
                        edge_nxt = edge_r + 6'h01;
                        if (edge_r == {lm1, 1'b1})
                        begin
                            rx_push = 1'b1;
                            ovr_set = (rx_cnt == FIFO_FULL);
                            state_nxt = cfg.phase ? ST_IDLE : ST_GAP;
                            if (master && !cfg.phase)
                            begin
                                pins_nxt.cs_n = 1'b1;
                            end
                        end
                    end
                end
                default:
                begin
                    // Chip select high between words in phase 0
                    if (master ? tick : cs_n_i)
                    begin
                        state_nxt = ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Shift engine registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_IDLE;
            div_r <= 16'h0000;
            edge_r <= 6'h00;
            txw_r <= 32'h00000000;
            rxw_r <= 32'h00000000;
            sprev_r <= 1'b0;
            pins_r <= '{sclk: 1'b0, sclk_oe_n: 1'b1, cs_n: 1'b1, cs_oe_n: 1'b1, dout: 1'b0, dout_oe_n: 1'b1};
        end
        else
        begin
            state_r <= state_nxt;
            div_r <= div_nxt;
            edge_r <= edge_nxt;
            txw_r <= txw_nxt;
            rxw_r <= rxw_nxt;
            sprev_r <= sclk_i;
            pins_r <= pins_nxt;
        end
    end

    // Wishbone decode: one-cycle ack, effects at the acking edge
    always_comb
    begin
        req = wb_cyc_i & wb_stb_i & ~ack_r;
        ack_nxt = req;
        dat_nxt = 32'h00000000;
        ctrl_a_nxt = ctrl_a_r;
        ctrl_b_nxt = ctrl_b_r;
        pre_nxt = pre_r;
        dma_nxt = dma_r;
        tx_push = 1'b0;
        rx_pop = 1'b0;
        ovr_nxt = ovr_r | ovr_set;
        und_nxt = und_r | und_set;
        if (req && wb_we_i)
        begin
            if (wb_adr_i == REG_CTRL_A)
            begin
                ctrl_a_nxt = merge(ctrl_a_r, wb_dat_i, wb_sel_i, CTRL_A_MASK);
            end
            else if (wb_adr_i == REG_CTRL_B)
            begin
                ctrl_b_nxt = merge(ctrl_b_r, wb_dat_i, wb_sel_i, CTRL_B_MASK);
            end
            else if (wb_adr_i == REG_DATA)
            begin
                tx_push = 1'b1;
            end
            else if (wb_adr_i == REG_STATUS)
            begin
                // A new event in the clearing cycle still sets
                ovr_nxt = ovr_set | (ovr_r & ~(wb_sel_i[0] & wb_dat_i[S_OVR_BIT]));
                und_nxt = und_set | (und_r & ~(wb_sel_i[0] & wb_dat_i[S_UND_BIT]));
            end
            else if (wb_adr_i == REG_PRESCALE)
            begin
                pre_nxt = merge(pre_r, wb_dat_i, wb_sel_i, PRESCALE_MASK);
            end
            else if (wb_adr_i == REG_DMA)
            begin
                dma_nxt = merge(dma_r, wb_dat_i, wb_sel_i, DMA_MASK);
            end
        end
        else if (req)
        begin
            if (wb_adr_i == REG_CTRL_A)
            begin
                dat_nxt = ctrl_a_r;
            end
            else if (wb_adr_i == REG_CTRL_B)
            begin
                dat_nxt = ctrl_b_r;
            end
            else if (wb_adr_i == REG_DATA)
            begin
                rx_pop = 1'b1;
                dat_nxt = (rx_cnt != 5'h00) ? rx_rdata : 32'h00000000;
            end
            else if (wb_adr_i == REG_STATUS)
            begin
                dat_nxt = {11'h000, rx_cnt, 3'h0, tx_cnt, 1'b0, und_r, ovr_r, state_r != ST_IDLE,
                           rx_cnt == FIFO_FULL, rx_cnt != 5'h00, tx_cnt != FIFO_FULL, tx_cnt == 5'h00};
            end
            else if (wb_adr_i == REG_PRESCALE)
            begin
                dat_nxt = pre_r;
            end
            else if (wb_adr_i == REG_DMA)
            begin
                dat_nxt = dma_r;
            end
        end
        // Requests are registered, so one late DMA word may be dropped
        dts_nxt = dma_r[DMA_TX_BIT] & (tx_cnt != FIFO_FULL);
        dtb_nxt = dma_r[DMA_TX_BIT] & (tx_cnt <= FIFO_FULL - BURST_WORDS);
        drs_nxt = dma_r[DMA_RX_BIT] & (rx_cnt != 5'h00);
        drb_nxt = dma_r[DMA_RX_BIT] & (rx_cnt >= BURST_WORDS);
    end

    // Register file and bus outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_a_r <= CTRL_A_RESET;
            ctrl_b_r <= CTRL_B_RESET;
            pre_r <= PRESCALE_RESET;
            dma_r <= 32'h00000000;
            dat_r <= 32'h00000000;
            ack_r <= 1'b0;
            ovr_r <= 1'b0;
            und_r <= 1'b0;
            dts_r <= 1'b0;
            dtb_r <= 1'b0;
            drs_r <= 1'b0;
            drb_r <= 1'b0;
        end
        else
        begin
            ctrl_a_r <= ctrl_a_nxt;
            ctrl_b_r <= ctrl_b_nxt;
            pre_r <= pre_nxt;
            dma_r <= dma_nxt;
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
            ovr_r <= ovr_nxt;
            und_r <= und_nxt;
            dts_r <= dts_nxt;
            dtb_r <= dtb_nxt;
            drs_r <= drs_nxt;
            drb_r <= drb_nxt;
        end
    end

    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
    assign pins_o = pins_r;
    assign dma_tx_sreq_o = dts_r;
    assign dma_tx_breq_o = dtb_r;
    assign dma_rx_sreq_o = drs_r;
    assign dma_rx_breq_o = drb_r;
endmodule

// ### tb_top.sv
// Self-checking bench for the serial peripheral port
`timescale 1ns/1ps
module tb_top;
    import spp_pkg::*;
    localparam logic [31:0] PAT = 32'h5ac396e1;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hf;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_q;
    logic [31:0] wb_rd;
    logic wb_ack;
    logic so;
    logic pha = 1'b0;
    logic pol = 1'b0;
    spp_pins_s pins;
    logic tx_sreq;
    logic tx_breq;
    logic rx_sreq;
    logic rx_breq;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    // Device and far-side slave; slave inputs unused in master runs
    spp_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
        .spi_in_i(so), .sclk_i(1'b0), .cs_n_i(1'b1), .pins_o(pins), .dma_tx_sreq_o(tx_sreq),
        .dma_tx_breq_o(tx_breq), .dma_rx_sreq_o(rx_sreq), .dma_rx_breq_o(rx_breq));
    spp_partner #(.PAT(PAT)) u_part (.pins_i(pins), .pha_i(pha), .pol_i(pol), .so_o(so));
    always #2 clk_i = ~clk_i;
    // Cut a hung run short
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask
    // Classic cycle: hold until ack is sampled, then release for a cycle
    task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        @(posedge clk_i);
        while (wb_ack !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50)
            failures++;
        wb_q = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask
    // Position of the k-th serial bit within the element
    function automatic int bit_idx(input int k, input int len, input logic [1:0] ord);
        case (ord)
            2'h0: return len - 1 - k;
            2'h3: return k;
            2'h1: return (k / 8) * 8 + 7 - k % 8;
            default: return (len / 8 - 1 - k / 8) * 8 + k % 8;
        endcase
    endfunction
    task automatic t_reset();
        logic [7:0] adr [6] = '{REG_CTRL_A, REG_CTRL_B, REG_PRESCALE, REG_DMA, REG_STATUS, 8'h20};
        logic [31:0] exp [6] = '{CTRL_A_RESET, CTRL_B_RESET, PRESCALE_RESET, 32'h0, 32'h3, 32'h0};
        chk("idle_pins", 32'(pins), 32'h1d);
        for (int i = 0; i < 6; i++)
        begin
            wb_io(1'b0, adr[i], 32'h0);
            chk("reset_reg", wb_q, exp[i]);
        end
    endtask
    task automatic t_regs();
        logic [7:0] adr [3] = '{REG_CTRL_A, REG_PRESCALE, REG_DMA};
        logic [31:0] msk [3] = '{CTRL_A_MASK, PRESCALE_MASK, DMA_MASK};
        logic [31:0] rst [3] = '{CTRL_A_RESET, PRESCALE_RESET, 32'h0};
        for (int i = 0; i < 3; i++)
        begin
            wb_io(1'b1, adr[i], 32'hffffffff);
            wb_io(1'b0, adr[i], 32'h0);
            chk("reg_mask", wb_q, msk[i]);
            wb_io(1'b1, adr[i], rst[i]);
        end
    endtask
    // Queue past full while disabled, send, then drain after disabling
    task automatic t_fill();
        int f0;
        f0 = u_part.frames;
        wb_io(1'b1, REG_DMA, 32'h3);
        for (int i = 0; i < 17; i++)
            wb_io(1'b1, REG_DATA, 32'hc0 + 32'(i));
        wb_io(1'b0, REG_STATUS, 32'h0);
        chk("tx_level", {27'h0, wb_q[12:8]}, 32'h10);
        chk("tx_dma", {30'h0, tx_sreq, tx_breq}, 32'h0);
        wb_io(1'b1, REG_CTRL_B, 32'h2);
        for (int n = 0; n < 8000 && u_part.frames != f0 + 16; n++)
            @(posedge clk_i);
        repeat (60) @(posedge clk_i);
        chk("frames", 32'(u_part.frames - f0), 32'h10);
        chk("last_out", {24'h0, u_part.rx_word[7:0]}, 32'hcf);
        wb_io(1'b1, REG_CTRL_B, 32'h0);
        wb_io(1'b0, REG_STATUS, 32'h0);
        chk("rx_level", {27'h0, wb_q[20:16]}, 32'h10);
        chk("dma_all", {28'h0, tx_sreq, tx_breq, rx_sreq, rx_breq}, 32'hf);
        for (int i = 0; i < 17; i++)
        begin
            wb_io(1'b0, REG_DATA, 32'h0);
            chk("rx_word", wb_q, (i < 16) ? PAT[31:24] : 32'h0);
        end
    endtask
    task automatic t_xfer(input logic p_ha, input logic p_ol, input logic [1:0] ord, input int len,
                          input logic [7:0] pre, input logic [7:0] rate);
        logic [31:0] w;
        logic [31:0] es;
        logic [31:0] er;
        int h;
        w = 32'h3c5aa596;
        es = 32'h0;
        er = 32'h0;
        for (int k = 0; k < len; k++)
        begin
            es[len - 1 - k] = w[bit_idx(k, len, ord)];
            er[bit_idx(k, len, ord)] = PAT[31 - k];
        end
        h = (pre / 2) * (rate + 1);
        h = (h < 16) ? 16 : h;
        pha <= p_ha;
        pol <= p_ol;
        // Setup order: divisor, both controls, data, then enable
        wb_io(1'b1, REG_PRESCALE, {24'h0, pre});
        wb_io(1'b1, REG_CTRL_A, {16'h0, rate, p_ol, p_ha, 1'b0, 5'(len - 1)});
        wb_io(1'b1, REG_CTRL_B, {24'h0, ord, ord, 4'h0});
        wb_io(1'b1, REG_DATA, w);
        wb_io(1'b1, REG_CTRL_B, {24'h0, ord, ord, 4'h2});
        for (int n = 0; n < 2000; n++)
        begin
            wb_io(1'b0, REG_STATUS, 32'h0);
            if (wb_q[4] === 1'b0 && wb_q[0] === 1'b1)
                break;
        end
        chk("serial_out", u_part.rx_word & (32'hffffffff >> (32 - len)), es);
        chk("half_ns", 32'(u_part.half_ns), 32'(h * 4));
        wb_io(1'b0, REG_DATA, 32'h0);
        chk("rx_in", wb_q, er);
        wb_io(1'b1, REG_CTRL_B, 32'h0);
    endtask
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_fill();
        t_regs();
        for (int m = 0; m < 4; m++)
            t_xfer(m[1], m[0], 2'h0, 8, 8'h02, 8'h00);
        for (int o = 0; o < 4; o++)
            t_xfer(1'b0, 1'b0, 2'(o), 16, 8'h02, 8'h00);
        t_xfer(1'b1, 1'b1, 2'h3, 24, 8'h04, 8'h0f);
        t_xfer(1'b0, 1'b1, 2'h1, 32, 8'h02, 8'h00);
        t_xfer(1'b1, 1'b0, 2'h3, 4, 8'h02, 8'h00);
        end_sim();
    end
endmodule
